// >>> core/lqt_top.sv
// Purpose: qos, scheduling and timeliness logic of a link entity
// Assumes: one request outstanding at a time; inputs synchronous to clock
// Notes: one retentive or non-retentive buffer holds one data unit
// Behaviour
// - three priorities carry 64/128/256 octets
// - missing priority defaults to time-available
// - negotiated priority only goes down
// - bounds unlimited or 1 ms to 60 s
// - unlimited bound never reports timeout
// - delay measured from request to confirm
// - coarse timers round bound up
// - bounds default to unlimited
// - auth level picks addressing and reporting
// - auth defaults ordinary, negotiates only up
// - explicit scheduling holds data until released
// - each release frees exactly one request
// - connection support services never deferred
// - scheduling default implicit, not management set
// - residence: read minus write below window
// - update: write minus sync below window
// - transparent keeps prior timeliness, else true
// - no timeliness always reports false
// - put stamp hidden when untimely
// - non-retentive buffer empties on read
module lqt_top import lqt_pkg::*; #(
  parameter int MS_CYCLES = `LQT_MS_CYCLES,
  parameter int RESID_MS = `LQT_RESID_MS,
  parameter int DW = 32
) (
  input wire logic clock, // 40 MHz system clock
  input wire logic resetn, // async reset, active low
  input wire logic req_valid, // user request present
  input wire lqt_req_t req, // request fields
  input wire logic user_explicit, // user scheduling choice
  input wire logic release_req, // release one deferred request
  input wire logic confirm_in, // matching confirm or completion
  input wire logic def_prio_set, // management set a default priority
  input wire lqt_prio_t def_prio, // management default priority
  input wire logic def_bound_set, // management set default bounds
  input wire lqt_bound_t def_conn_bound, // default setup-class bound
  input wire lqt_bound_t def_data_bound, // default data-class bound
  input wire logic def_auth_set, // management set a default auth
  input wire lqt_auth_t def_auth, // management default auth
  input wire logic neg_valid, // connection negotiation result in
  input wire lqt_prio_t neg_req_prio, // priority asked for
  input wire lqt_prio_t neg_offer_prio, // priority offered by peer
  input wire lqt_auth_t neg_offer_auth, // auth offered by peer
  input wire lqt_tmode_t tmode, // timeliness kind
  input wire logic [`LQT_TS_W-1:0] window_ms, // timeliness window
  input wire logic retentive, // buffer keeps data after read
  input wire logic buf_wr, // buffer write (put or reception)
  input wire logic [DW-1:0] buf_wr_data, // data written
  input wire logic buf_wr_has_tl, // write carries prior timeliness
  input wire logic buf_wr_tl, // prior timeliness value
  input wire logic buf_rd, // buffer read (get or transmission)
  input wire logic sync_event, // buffer filled or transmitted event
  output logic req_ready, // idle, next request taken
  output logic issue_valid, // request proceeds to peers
  output lqt_svc_t issue_svc, // service issued
  output lqt_prio_t issue_prio, // priority in effect
  output logic issue_time_crit, // urgent or normal
  output logic done_valid, // request finished
  output lqt_status_t done_status, // completion status
  output lqt_prio_t conn_prio, // negotiated priority
  output lqt_auth_t auth_level, // auth level in effect
  output logic src_addr_en, // add source address
  output logic local_sched, // run scheduling locally
  output logic residual_report, // low-rate state report pulse
  output logic [`LQT_TS_W-1:0] time_now, // millisecond time
  output logic rd_valid, // read result valid
  output logic [DW-1:0] rd_data, // data read
  output logic rd_timely, // timeliness of data read
  output logic [`LQT_TS_W-1:0] rd_stamp, // write time, zero if untimely
  output logic buf_full // buffer holds a unit
);
  localparam int TW = `LQT_TS_W;
  localparam int RW = $clog2(RESID_MS + 1);

  if (MS_CYCLES < 2 || RESID_MS < 1 || DW < 1) begin : g_chk
    $error("lqt_top: unsupported parameter values");
  end

  function automatic logic [1:0] lower_of(input logic [1:0] a, input logic [1:0] b);
    return (a > b) ? a : b;
  endfunction

  function automatic logic exempt(input lqt_svc_t s);
    return !(s == LQT_SVC_DATA || s == LQT_SVC_UDATA_LOC || s == LQT_SVC_UDATA_REM);
  endfunction

  function automatic logic [`LQT_LEN_W-1:0] max_len(input lqt_prio_t p);
    case (p)
      LQT_URGENT: return `LQT_MAX_URGENT;
      LQT_NORMAL: return `LQT_MAX_NORMAL;
      default: return `LQT_MAX_TAVAIL;
    endcase
  endfunction

  // time base
  logic [$clog2(MS_CYCLES)-1:0] div_ff, nxt_div;
  logic tick_ff, nxt_tick;
  logic [TW-1:0] now_ff, nxt_now;

  always_comb begin
    nxt_tick = 1'b0;
    nxt_now = now_ff;
    nxt_div = div_ff + 1'b1;
    if (div_ff == $bits(div_ff)'(MS_CYCLES - 1)) begin
      nxt_div = '0;
      nxt_tick = 1'b1;
      nxt_now = now_ff + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
      now_ff <= `LQT_TS_ZERO;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
      now_ff <= nxt_now;
    end
  end

  // request sequencing
  lqt_state_t st_ff, nxt_st;
  lqt_svc_t svc_ff, nxt_svc;
  lqt_prio_t prio_ff, nxt_prio;
  logic unlim_ff, nxt_unlim;
  logic iss_ff, nxt_iss, crit_ff, nxt_crit, done_ff, nxt_done, rdy_ff, nxt_rdy;
  lqt_status_t sts_ff, nxt_sts;
  lqt_prio_t eff_prio;
  lqt_bound_t eff_bound, dflt_bound;
  logic accept, tmr_start, tmr_stop, tmr_to;

  always_comb begin
    accept = req_valid && rdy_ff;
    eff_prio = req.has_prio ? req.prio : (def_prio_set ? def_prio : LQT_TAVAIL);
    dflt_bound = exempt(req.svc) || req.svc == LQT_SVC_UDATA_REM ? def_conn_bound : def_data_bound;
    if (!def_bound_set) begin
      dflt_bound = '{unlim: 1'b1, ms: '0};
    end
    eff_bound = req.has_bound ? req.bound : dflt_bound;
    // clamp to 1 ms .. 60 s
    if (eff_bound.ms < `LQT_BOUND_MIN) begin
      eff_bound.ms = `LQT_BOUND_MIN;
    end else if (eff_bound.ms > `LQT_BOUND_MAX) begin
      eff_bound.ms = `LQT_BOUND_MAX;
    end
    nxt_st = st_ff;
    nxt_svc = svc_ff;
    nxt_prio = prio_ff;
    nxt_unlim = unlim_ff;
    nxt_iss = 1'b0;
    nxt_crit = crit_ff;
    nxt_done = 1'b0;
    nxt_sts = sts_ff;
    tmr_start = 1'b0;
    tmr_stop = 1'b0;
    case (st_ff)
      LQT_ST_IDLE: begin
        if (accept) begin
          nxt_svc = req.svc;
          nxt_prio = eff_prio;
          nxt_crit = (eff_prio != LQT_TAVAIL);
          nxt_unlim = eff_bound.unlim;
          if (req.len > max_len(eff_prio)) begin
            nxt_done = 1'b1;
            nxt_sts = LQT_STS_OVERSIZE;
          end else begin
            tmr_start = 1'b1;
            if (user_explicit && !exempt(req.svc)) begin
              nxt_st = LQT_ST_DEFER;
            end else begin
              nxt_st = LQT_ST_WAIT;
              nxt_iss = 1'b1;
            end
          end
        end
      end
      LQT_ST_DEFER: begin
        if (tmr_to) begin
          nxt_st = LQT_ST_IDLE;
          nxt_done = 1'b1;
          nxt_sts = LQT_STS_TIMEOUT;
        end else if (release_req) begin
          nxt_st = LQT_ST_WAIT;
          nxt_iss = 1'b1;
        end
      end
      LQT_ST_WAIT: begin
        // a confirm racing the expiry wins: the peer did answer in time
        if (confirm_in) begin
          tmr_stop = 1'b1;
          nxt_st = LQT_ST_IDLE;
          nxt_done = 1'b1;
          nxt_sts = LQT_STS_OK;
        end else if (tmr_to) begin
          nxt_st = LQT_ST_IDLE;
          nxt_done = 1'b1;
          nxt_sts = LQT_STS_TIMEOUT;
        end
      end
      default: nxt_st = LQT_ST_IDLE;
    endcase
    nxt_rdy = (nxt_st == LQT_ST_IDLE);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_ff <= LQT_ST_IDLE;
      svc_ff <= LQT_SVC_CONNECT;
      prio_ff <= LQT_TAVAIL;
      unlim_ff <= 1'b1;
      iss_ff <= 1'b0;
      crit_ff <= 1'b0;
      done_ff <= 1'b0;
      sts_ff <= LQT_STS_OK;
      rdy_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      svc_ff <= nxt_svc;
      prio_ff <= nxt_prio;
      unlim_ff <= nxt_unlim;
      iss_ff <= nxt_iss;
      crit_ff <= nxt_crit;
      done_ff <= nxt_done;
      sts_ff <= nxt_sts;
      rdy_ff <= nxt_rdy;
    end
  end

  lqt_conf_timer #(.BW(`LQT_BOUND_W)) u_timer (
    .clock(clock),
    .resetn(resetn),
    .start(tmr_start),
    .stop(tmr_stop),
    .unlim(eff_bound.unlim),
    .bound_ms(eff_bound.ms),
    .ms_tick(tick_ff),
    .timeout(tmr_to)
  );

  // negotiation and authentication
  lqt_prio_t cprio_ff, nxt_cprio;
  lqt_auth_t auth_ff, nxt_auth;
  logic auth_init_ff, nxt_auth_init, resid_ff, nxt_resid;
  logic src_ff, nxt_src, loc_ff, nxt_loc;
  logic [RW-1:0] rcnt_ff, nxt_rcnt;

  always_comb begin
    nxt_cprio = cprio_ff;
    nxt_auth = auth_ff;
    nxt_auth_init = 1'b1;
    // ordinary unless managed, taken after reset
    if (!auth_init_ff) begin
      nxt_auth = def_auth_set ? def_auth : LQT_ORDINARY;
    end else if (neg_valid) begin
      nxt_cprio = lqt_prio_t'(lower_of(neg_req_prio, neg_offer_prio));
      nxt_auth = lqt_auth_t'(lower_of(auth_ff, neg_offer_auth));
    end
    // addressing follows the level in effect
    nxt_src = (nxt_auth != LQT_ORDINARY);
    nxt_loc = (nxt_auth == LQT_MAXIMAL);
    nxt_resid = 1'b0;
    nxt_rcnt = rcnt_ff;
    if (auth_ff != LQT_MAXIMAL || st_ff != LQT_ST_IDLE) begin
      nxt_rcnt = '0;
    end else if (tick_ff) begin
      nxt_rcnt = rcnt_ff + 1'b1;
      if (rcnt_ff == RW'(RESID_MS - 1)) begin
        nxt_rcnt = '0;
        nxt_resid = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cprio_ff <= LQT_TAVAIL;
      auth_ff <= LQT_ORDINARY;
      auth_init_ff <= 1'b0;
      src_ff <= 1'b0;
      loc_ff <= 1'b0;
      resid_ff <= 1'b0;
      rcnt_ff <= '0;
    end else begin
      cprio_ff <= nxt_cprio;
      auth_ff <= nxt_auth;
      auth_init_ff <= nxt_auth_init;
      src_ff <= nxt_src;
      loc_ff <= nxt_loc;
      resid_ff <= nxt_resid;
      rcnt_ff <= nxt_rcnt;
    end
  end

  // buffer and timeliness
  logic full_ff, nxt_full, has_tl_ff, nxt_has_tl, ptl_ff, nxt_ptl, upd_ff, nxt_upd;
  logic sseen_ff, nxt_sseen, wafter_ff, nxt_wafter, rv_ff, nxt_rv, rtl_ff, nxt_rtl;
  logic [DW-1:0] data_ff, nxt_data, rd_ff, nxt_rd;
  logic [TW-1:0] wt_ff, nxt_wt, st_t_ff, nxt_st_t, stamp_ff, nxt_stamp;
  logic tl;

  always_comb begin
    nxt_full = full_ff;
    nxt_has_tl = has_tl_ff;
    nxt_ptl = ptl_ff;
    nxt_upd = upd_ff;
    nxt_data = data_ff;
    nxt_wt = wt_ff;
    nxt_sseen = sseen_ff || sync_event;
    nxt_st_t = sync_event ? now_ff : st_t_ff;
    // a sync after the write makes write minus sync negative
    nxt_wafter = sync_event ? 1'b0 : wafter_ff;
    nxt_rv = 1'b0;
    nxt_rd = rd_ff;
    nxt_rtl = rtl_ff;
    nxt_stamp = stamp_ff;
    tl = 1'b0;
    case (tmode)
      LQT_TL_RESIDENCE: tl = (now_ff - wt_ff) < window_ms;
      LQT_TL_UPDATE: tl = upd_ff;
      LQT_TL_SYNC: tl = wafter_ff && ((now_ff - st_t_ff) < window_ms);
      LQT_TL_TRANSPARENT: tl = has_tl_ff ? ptl_ff : 1'b1;
      default: tl = 1'b0;
    endcase
    if (buf_rd && full_ff) begin
      nxt_rv = 1'b1;
      nxt_rd = data_ff;
      nxt_rtl = tl;
      nxt_stamp = tl ? wt_ff : `LQT_TS_ZERO;
      nxt_full = retentive;
    end
    // a write in the read cycle lands after the read, so it is never lost
    if (buf_wr) begin
      nxt_full = 1'b1;
      nxt_data = buf_wr_data;
      nxt_wt = now_ff;
      nxt_has_tl = buf_wr_has_tl;
      nxt_ptl = buf_wr_tl;
      nxt_wafter = sseen_ff || sync_event;
      // a sync in the write cycle is zero distance, still bounded by the window
      nxt_upd = nxt_wafter && ((now_ff - nxt_st_t) < window_ms);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      full_ff <= 1'b0;
      has_tl_ff <= 1'b0;
      ptl_ff <= 1'b0;
      upd_ff <= 1'b0;
      sseen_ff <= 1'b0;
      wafter_ff <= 1'b0;
      rv_ff <= 1'b0;
      rtl_ff <= 1'b0;
      data_ff <= '0;
      rd_ff <= '0;
      wt_ff <= `LQT_TS_ZERO;
      st_t_ff <= `LQT_TS_ZERO;
      stamp_ff <= `LQT_TS_ZERO;
    end else begin
      full_ff <= nxt_full;
      has_tl_ff <= nxt_has_tl;
      ptl_ff <= nxt_ptl;
      upd_ff <= nxt_upd;
      sseen_ff <= nxt_sseen;
      wafter_ff <= nxt_wafter;
      rv_ff <= nxt_rv;
      rtl_ff <= nxt_rtl;
      data_ff <= nxt_data;
      rd_ff <= nxt_rd;
      wt_ff <= nxt_wt;
      st_t_ff <= nxt_st_t;
      stamp_ff <= nxt_stamp;
    end
  end

  assign req_ready = rdy_ff;
  assign issue_valid = iss_ff;
  assign issue_svc = svc_ff;
  assign issue_prio = prio_ff;
  assign issue_time_crit = crit_ff;
  assign done_valid = done_ff;
  assign done_status = sts_ff;
  assign conn_prio = cprio_ff;
  assign auth_level = auth_ff;
  assign src_addr_en = src_ff;
  assign local_sched = loc_ff;
  assign residual_report = resid_ff;
  assign time_now = now_ff;
  assign rd_valid = rv_ff;
  assign rd_data = rd_ff;
  assign rd_timely = rtl_ff;
  assign rd_stamp = stamp_ff;
  assign buf_full = full_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_unlim_no_timeout: assert property (done_ff && sts_ff == LQT_STS_TIMEOUT |-> !unlim_ff)
    else $error("timeout on unlimited bound");
  a_oversize_done: assert property (accept && req.len > max_len(eff_prio) |=> done_ff && sts_ff == LQT_STS_OVERSIZE && !iss_ff)
    else $error("oversize request not refused");
  a_default_prio: assert property (accept && !req.has_prio && !def_prio_set |=> prio_ff == LQT_TAVAIL)
    else $error("missing priority not time-available");
  a_release_one: assert property (st_ff == LQT_ST_DEFER && !release_req && !tmr_to |=> !iss_ff)
    else $error("deferred request issued without release");
  a_exempt_flow: assert property (accept && exempt(req.svc) && req.len <= max_len(eff_prio) |=> iss_ff && st_ff == LQT_ST_WAIT)
    else $error("support service deferred");
  a_neg_prio_down: assert property (neg_valid && auth_init_ff |=> cprio_ff >= $past(neg_req_prio))
    else $error("priority raised in negotiation");
  a_neg_auth_up: assert property (auth_init_ff |=> auth_ff >= $past(auth_ff))
    else $error("auth level lowered");
  a_none_false: assert property (buf_rd && full_ff && tmode == LQT_TL_NONE |=> rv_ff && !rtl_ff)
    else $error("timeliness true without selection");
  a_stamp_hidden: assert property (rv_ff && !rtl_ff |-> stamp_ff == `LQT_TS_ZERO)
    else $error("stamp shown for untimely data");
  a_nonret_empty: assert property (buf_rd && full_ff && !retentive && !buf_wr |=> !full_ff)
    else $error("non-retentive buffer kept data");
  a_tick_steady: assert property (tick_ff |=> !tick_ff ##0 now_ff == $past(now_ff))
    else $error("millisecond tick malformed");
  c_timeout: cover property (done_ff && sts_ff == LQT_STS_TIMEOUT);
  c_release: cover property (st_ff == LQT_ST_DEFER ##1 iss_ff);
  c_timely_read: cover property (rv_ff && rtl_ff && tmode == LQT_TL_SYNC);
  c_residual: cover property (resid_ff);
endmodule // lqt_top

// >>> core/lqt_cfg.svh
// Purpose: named constants of the link qos and timeliness unit
// Assumes: 40 MHz system clock
// Notes: definitions only
`ifndef LQT_CFG_SVH
`define LQT_CFG_SVH
`define LQT_CLK_NS 25
`define LQT_MS_NS 1000000
`define LQT_MS_CYCLES (`LQT_MS_NS / `LQT_CLK_NS)
`define LQT_LEN_W 9
`define LQT_MAX_URGENT 9'h040
`define LQT_MAX_NORMAL 9'h080
`define LQT_MAX_TAVAIL 9'h100
`define LQT_BOUND_W 16
`define LQT_BOUND_MIN 16'h0001
`define LQT_BOUND_MAX 16'hea60
`define LQT_TS_W 32
`define LQT_TS_ZERO 32'h0000_0000
`define LQT_RESID_MS 1000
`endif

// >>> core/lqt_pkg.sv
// Purpose: types shared by the link qos and timeliness unit
// Assumes: lqt_cfg.svh supplies widths
// Notes: priority codes grow toward lower urgency, auth codes toward more addressing
`include "lqt_cfg.svh"
package lqt_pkg;
  typedef enum logic [1:0] {LQT_URGENT = 2'h0, LQT_NORMAL = 2'h1, LQT_TAVAIL = 2'h2} lqt_prio_t;
  typedef enum logic [1:0] {LQT_ORDINARY = 2'h0, LQT_SOURCE = 2'h1, LQT_MAXIMAL = 2'h2} lqt_auth_t;
  // remote unitdata also covers the exchange service: both share one bound class
  typedef enum logic [2:0] {
    LQT_SVC_CONNECT = 3'h0, LQT_SVC_REINIT = 3'h1, LQT_SVC_TEARDOWN = 3'h2,
    LQT_SVC_SUBPOLL = 3'h3, LQT_SVC_LISPOLL = 3'h4, LQT_SVC_DATA = 3'h5,
    LQT_SVC_UDATA_LOC = 3'h6, LQT_SVC_UDATA_REM = 3'h7
  } lqt_svc_t;
  typedef enum logic [2:0] {
    LQT_TL_NONE = 3'h0, LQT_TL_RESIDENCE = 3'h1, LQT_TL_UPDATE = 3'h2,
    LQT_TL_SYNC = 3'h3, LQT_TL_TRANSPARENT = 3'h4
  } lqt_tmode_t;
  typedef enum logic [1:0] {LQT_ST_IDLE = 2'b00, LQT_ST_DEFER = 2'b01, LQT_ST_WAIT = 2'b11} lqt_state_t;
  typedef enum logic [1:0] {LQT_STS_OK = 2'h0, LQT_STS_TIMEOUT = 2'h1, LQT_STS_OVERSIZE = 2'h2} lqt_status_t;
  typedef struct packed {
    logic unlim;
    logic [`LQT_BOUND_W-1:0] ms;
  } lqt_bound_t;
  typedef struct packed {
    lqt_svc_t svc;
    logic has_prio;
    lqt_prio_t prio;
    logic has_bound;
    lqt_bound_t bound;
    logic [`LQT_LEN_W-1:0] len;
  } lqt_req_t;
endpackage

// >>> core/lqt_conf_timer.sv
// Purpose: confirm-delay supervisor for one outstanding request
// Assumes: ms_tick is a one-cycle pulse once per millisecond
// Notes: fires between bound and bound+1 ms after start, never early
module lqt_conf_timer import lqt_pkg::*; #(
  parameter int BW = `LQT_BOUND_W
) (
  input wire logic clock, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic start, // arm with a new bound
  input wire logic stop, // disarm, request finished
  input wire logic unlim, // bound is unlimited
  input wire logic [BW-1:0] bound_ms, // bound in ms
  input wire logic ms_tick, // millisecond pulse
  output logic timeout // one-cycle expiry pulse
);
  logic armed_ff, nxt_armed;
  logic unlim_ff, nxt_unlim;
  logic [BW-1:0] left_ff, nxt_left;
  logic timeout_ff, nxt_timeout;

  always_comb begin
    nxt_armed = armed_ff;
    nxt_unlim = unlim_ff;
    nxt_left = left_ff;
    nxt_timeout = 1'b0;
    if (start) begin
      nxt_armed = 1'b1;
      nxt_unlim = unlim;
      nxt_left = bound_ms;
    end else if (stop) begin
      nxt_armed = 1'b0;
    end else if (armed_ff && ms_tick && !unlim_ff) begin
      if (left_ff == '0) begin
        nxt_armed = 1'b0;
        nxt_timeout = 1'b1;
      end else begin
        nxt_left = left_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      armed_ff <= 1'b0;
      unlim_ff <= 1'b1;
      left_ff <= '0;
      timeout_ff <= 1'b0;
    end else begin
      armed_ff <= nxt_armed;
      unlim_ff <= nxt_unlim;
      left_ff <= nxt_left;
      timeout_ff <= nxt_timeout;
    end
  end

  assign timeout = timeout_ff;
endmodule // lqt_conf_timer

// >>> test/lqt_peer_model.sv
// Purpose: far-side model that answers each issued request with a confirm
// Assumes: one request outstanding at a time
// Notes: dly sets a prompt or slow answer; en low means no answer at all
module lqt_peer_model (
  input wire logic clock, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic issue_valid, // request reached the peers
  input wire logic en, // answer at all
  input wire logic [7:0] dly, // cycles from issue to confirm
  output logic confirm_in // one-cycle confirm pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      confirm_in <= 1'b0;
    end else begin
      confirm_in <= 1'b0;
      if (issue_valid && en) begin
        cnt <= dly;
      end else if (cnt == 1) begin
        confirm_in <= 1'b1;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // lqt_peer_model

// >>> test/test_lqt_top.sv
// Purpose: self-checking bench of the link qos and timeliness unit
// Assumes: MS_CYCLES 4 and RESID_MS 2 keep the run short
// Notes: expected times come from time_now sampled half a cycle after a tick
module test_lqt_top import lqt_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, resetn = 0, req_valid = 0, user_explicit = 0, release_req = 0;
  logic neg_valid = 0, retentive = 0, buf_wr = 0, buf_wr_has_tl = 0, buf_wr_tl = 0;
  logic buf_rd = 0, sync_event = 0, peer_en = 0, confirm_in, def_prio_set = 0, def_bound_set = 0;
  logic req_ready, issue_valid, issue_time_crit, done_valid, src_addr_en, local_sched;
  logic residual_report, rd_valid, rd_timely, buf_full;
  lqt_req_t req = '0;
  lqt_prio_t def_prio = LQT_URGENT, neg_req_prio = LQT_URGENT, neg_offer_prio = LQT_URGENT;
  lqt_prio_t issue_prio, conn_prio;
  lqt_auth_t def_auth = LQT_ORDINARY, neg_offer_auth = LQT_ORDINARY, auth_level;
  lqt_bound_t def_conn_bound = '0, def_data_bound = '0;
  lqt_tmode_t tmode = LQT_TL_NONE;
  lqt_svc_t issue_svc;
  lqt_status_t done_status;
  logic [31:0] window_ms = 0, buf_wr_data = 0, time_now, rd_data, rd_stamp;
  logic [7:0] peer_dly = 2;
  int failures = 0, check_count = 0, ev, n, mx, ep, am;
  lqt_top #(.MS_CYCLES(4), .RESID_MS(2), .DW(32)) dut (.clock, .resetn, .req_valid, .req,
    .user_explicit, .release_req, .confirm_in, .def_prio_set, .def_prio,
    .def_bound_set, .def_conn_bound, .def_data_bound, .def_auth_set(1'b0), .def_auth,
    .neg_valid, .neg_req_prio, .neg_offer_prio, .neg_offer_auth, .tmode, .window_ms,
    .retentive, .buf_wr, .buf_wr_data, .buf_wr_has_tl, .buf_wr_tl, .buf_rd, .sync_event,
    .req_ready, .issue_valid, .issue_svc, .issue_prio, .issue_time_crit, .done_valid,
    .done_status, .conn_prio, .auth_level, .src_addr_en, .local_sched, .residual_report,
    .time_now, .rd_valid, .rd_data, .rd_timely, .rd_stamp, .buf_full);
  lqt_peer_model peer (.clock, .resetn, .issue_valid, .en(peer_en), .dly(peer_dly),
    .confirm_in);
  always #12.5 clock = ~clock;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask
  task automatic wait_ev(input int lim);
    ev = 0;
    for (n = 0; n < lim && ev == 0; n++) begin
      if (issue_valid === 1'b1) ev = 1;
      else if (done_valid === 1'b1) ev = 2;
      else @(negedge clock);
    end
  endtask
  task automatic send(lqt_svc_t s, logic hp, lqt_prio_t p, logic hb, logic ul, int ms,
                      int len, logic ex);
    req = '{s, hp, p, hb, '{ul, 16'(ms)}, 9'(len)};
    user_explicit = ex;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
  endtask
  task automatic flow(int lim, lqt_status_t st);
    wait_ev(3);
    chk(ev, 1);
    @(negedge clock);
    wait_ev(lim);
    chk(ev, 2);
    chk(done_status, st);
  endtask
  // wait for a tick, then stand half a cycle after it so stamps are unambiguous
  task automatic sync_ms();
    logic [31:0] t;
    t = time_now;
    while (time_now === t) @(negedge clock);
  endtask
  task automatic buf_case(lqt_tmode_t m, int w, int sd, int d, logic ht, logic tl, logic rt);
    int ts, tw, tr;
    logic e;
    tmode = m;
    window_ms = w;
    retentive = rt;
    buf_wr_has_tl = ht;
    buf_wr_tl = tl;
    buf_wr_data = $urandom;
    ts = -1;
    if (sd > 0) begin
      sync_ms();
      ts = time_now;
      pulse(sync_event);
      repeat (sd - 1) sync_ms();
    end
    sync_ms();
    tw = time_now;
    pulse(buf_wr);
    repeat (d) sync_ms();
    tr = time_now;
    pulse(buf_rd);
    case (m)
      LQT_TL_RESIDENCE: e = (tr - tw) < w;
      LQT_TL_UPDATE: e = ts >= 0 && (tw - ts) < w;
      LQT_TL_SYNC: e = ts >= 0 && (tr - ts) < w;
      LQT_TL_TRANSPARENT: e = ht ? tl : 1'b1;
      default: e = 1'b0;
    endcase
    chk(rd_valid, 1);
    chk(rd_data, buf_wr_data);
    chk(rd_timely, e);
    chk(rd_stamp, e ? tw : 0);
    chk(buf_full, rt);
  endtask
  initial begin
    #200000;
    failures++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h4da4));
    def_prio = lqt_prio_t'($urandom_range(2, 0));
    def_auth = lqt_auth_t'($urandom_range(2, 0));
    def_data_bound = '{1'b0, 16'($urandom_range(100, 1))};
    // data bound kept within setup bound
    def_conn_bound = '{1'b0, def_data_bound.ms + 16'h0064};
    repeat (5) @(negedge clock);
    resetn = 1'b1;
    repeat (2) @(negedge clock);
    chk(auth_level, LQT_ORDINARY);
    peer_en = 1'b1;
    for (int p = 0; p < 4; p++) begin
      ep = p < 3 ? p : 2;
      mx = 64 << ep;
      send(LQT_SVC_DATA, p < 3, lqt_prio_t'(ep), 0, 0, 0, mx + 1, 0);
      wait_ev(3);
      chk(ev, 2);
      chk(done_status, LQT_STS_OVERSIZE);
      @(negedge clock);
      send(LQT_SVC_DATA, p < 3, lqt_prio_t'(ep), 0, 0, 0, $urandom_range(mx, 1), 0);
      chk(issue_prio, ep);
      chk(issue_time_crit, ep < 2);
      chk(issue_svc, LQT_SVC_DATA);
      flow(10, LQT_STS_OK);
    end
    def_prio_set = 1'b1;
    send(LQT_SVC_DATA, 0, LQT_URGENT, 0, 0, 0, 8, 0);
    chk(issue_prio, def_prio);
    flow(10, LQT_STS_OK);
    def_prio_set = 1'b0;
    def_bound_set = 1'b1;
    peer_en = 1'b0;
    send(LQT_SVC_DATA, 1, LQT_URGENT, 0, 0, 0, 8, 0);
    flow(420, LQT_STS_TIMEOUT);
    chk(n >= 4 * def_data_bound.ms + 1 && n <= 4 * def_data_bound.ms + 4, 1);
    def_bound_set = 1'b0;
    send(LQT_SVC_CONNECT, 1, LQT_NORMAL, 1, 0, 1, 4, 0);
    flow(20, LQT_STS_TIMEOUT);
    chk(n >= 5 && n <= 9, 1);
    peer_en = 1'b1;
    peer_dly = 40;
    send(LQT_SVC_UDATA_REM, 1, LQT_URGENT, 1, 1, 1, 8, 0);
    flow(50, LQT_STS_OK);
    peer_dly = 2;
    send(LQT_SVC_CONNECT, 1, LQT_URGENT, 0, 0, 0, 8, 1);
    flow(10, LQT_STS_OK);
    pulse(release_req);
    // buffer sender side picks explicit scheduling
    send(LQT_SVC_DATA, 1, LQT_URGENT, 0, 0, 0, 8, 1);
    wait_ev(8);
    chk(ev, 0);
    pulse(release_req);
    flow(10, LQT_STS_OK);
    am = 0;
    for (int a = 0; a < 3; a++) begin
      for (int b = 0; b < 3; b++) begin
        neg_req_prio = lqt_prio_t'(a);
        neg_offer_prio = lqt_prio_t'(b);
        neg_offer_auth = lqt_auth_t'(b);
        am = b > am ? b : am;
        pulse(neg_valid);
        chk(conn_prio, a > b ? a : b);
        chk(auth_level, am);
        @(negedge clock);
      end
    end
    chk(src_addr_en, 1);
    chk(local_sched, 1);
    for (n = 0; n < 12 && residual_report !== 1'b1; n++) @(negedge clock);
    chk(residual_report, 1);
    buf_case(LQT_TL_RESIDENCE, 3, 0, 1, 0, 0, 0);
    buf_case(LQT_TL_RESIDENCE, 3, 0, 3, 0, 0, 1);
    buf_case(LQT_TL_UPDATE, 2, 1, 1, 0, 0, 0);
    buf_case(LQT_TL_UPDATE, 2, 2, 1, 0, 0, 0);
    buf_case(LQT_TL_SYNC, 3, 1, 1, 0, 0, 0);
    buf_case(LQT_TL_SYNC, 3, 1, 2, 0, 0, 0);
    buf_case(LQT_TL_TRANSPARENT, 1, 0, 1, 0, 0, 0);
    buf_case(LQT_TL_TRANSPARENT, 1, 0, 1, 1, 0, 0);
    buf_case(LQT_TL_NONE, 9, 0, 1, 1, 1, 0);
    end_sim();
  end
endmodule // test_lqt_top
